// ==== tb/mbop_buffer_unit_asserts.sv ====
// Port-level checks for the buffer unit
`include "mbop_cfg.svh"
module mbop_bu_asserts (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        mem_req,
    input wire logic        mem_req_write,
    input wire logic [20:0] mem_req_addr,
    input wire logic [7:0]  mem_wr_zone,
    input wire logic        mem_req_ready,
    input wire logic        param_valid,
    input wire logic [2:0]  param_idx,
    input wire logic        pairs_valid,
    input wire logic        pairs_ready,
    input wire logic [63:0] second_operand_pair
);
    // One clock domain, one reset
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_req_addr_hold: assert property (mem_req && !mem_req_ready |=> mem_req && $stable(mem_req_addr))
        else $error("request dropped before ready");
    a_req_kind_hold: assert property (mem_req && !mem_req_ready |=> $stable(mem_req_write))
        else $error("request kind changed while waiting");
    a_zone_hold: assert property (mem_req && mem_req_write && !mem_req_ready |=> $stable(mem_wr_zone))
        else $error("write zone changed while waiting");
    a_zone_used: assert property (mem_req && mem_req_write |-> mem_wr_zone != 8'h00)
        else $error("write with empty zone");
    a_pair_hold: assert property (pairs_valid && !pairs_ready |=> pairs_valid && $stable(second_operand_pair))
        else $error("operand pair dropped before ready");
    a_start_a_issue: assert property (param_valid && param_idx == `MBOP_PARAM_A_ADDR |-> ##[1:8] mem_req)
        else $error("start address A not issued");
    a_start_b_issue: assert property (param_valid && param_idx == `MBOP_PARAM_B_ADDR |-> ##[1:8] mem_req)
        else $error("start address B not issued");
    a_reset_quiet: assert property ($fell(rst) |-> !mem_req && !pairs_valid)
        else $error("outputs active out of reset");
endmodule
bind mbop_buffer_unit mbop_bu_asserts u_chk (.clk, .rst, .mem_req, .mem_req_write, .mem_req_addr, .mem_wr_zone,
    .mem_req_ready, .param_valid, .param_idx, .pairs_valid, .pairs_ready, .second_operand_pair);

// ==== tb/mbop_buffer_unit_tb.sv ====
// Self-checking bench for the buffer unit
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin failures++; \
    $display("Error %s expected %h seen %h", n, e, a); end end
module mbop_buffer_unit_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, rst, mem_rd_valid, mem_rd_to_y, mem_req, mem_req_write, mem_req_ready, slow, op_req, op_new_octet;
    logic op_to_y, op_x_to_first, op_busy, reg_load, imm_load, imm_to_first, reg_to_first, param_valid, res_valid;
    logic res_stall, maint_store, maint_from_y, copy_wb, copy_wb_to_y, fill_req, pairs_valid, pairs_ready;
    logic [255:0] mem_rd_data, mem_wr_data;
    logic [20:0]  mem_req_addr, op_octet_addr, maint_addr, res_octet_addr, vec_a_start, vec_b_start, vec_c_start, base;
    logic [7:0]   mem_wr_zone;
    logic [3:0]   op_elem, res_elem;
    logic [2:0]   param_idx;
    logic [1:0]   op_size, op_src, res_size;
    logic [63:0]  reg_data, imm_data, res_data, first_operand_pair, second_operand_pair, e64;
    logic [63:0]  exp_q[$]; // Expected memory operands, oldest first
    int           failures, samples_checked, seed, n;
    // Selection model: singles on top, halves sign extended
    function automatic logic [63:0] pick(input logic [255:0] o, input logic [3:0] e, input logic [1:0] s);
        logic [31:0] w;
        w = o[255 - 32 * e[3:1] -: 32];
        if (s == 2'h0)
            pick = {{16{e[0] ? w[15] : w[31]}}, e[0] ? w[15:0] : w[31:16], 32'h0};
        else if (s == 2'h1)
            pick = {w, 32'h0};
        else
            pick = o[255 - 64 * e[3:2] -: 64];
    endfunction
    // 50 MHz clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    mbop_buffer_unit dut (.clk, .rst, .mem_rd_valid, .mem_rd_data, .mem_rd_to_y, .mem_req, .mem_req_write,
        .mem_req_addr, .mem_wr_data, .mem_wr_zone, .mem_req_ready, .op_req, .op_new_octet, .op_octet_addr, .op_elem,
        .op_to_y, .op_size, .op_src, .op_x_to_first, .op_busy, .reg_load, .reg_data, .imm_load, .imm_data,
        .imm_to_first, .reg_to_first, .param_valid, .param_idx, .vec_a_start, .vec_b_start, .vec_c_start, .res_valid,
        .res_octet_addr, .res_elem, .res_size, .res_data, .res_stall, .maint_store, .maint_from_y, .maint_addr,
        .copy_wb, .copy_wb_to_y, .fill_req, .first_operand_pair, .second_operand_pair, .pairs_valid, .pairs_ready);
    mbop_mem_model u_mem (.clk, .slow, .mem_req, .mem_req_write, .mem_req_addr, .mem_req_ready, .mem_rd_valid,
        .mem_rd_data);
    task automatic final_report;
        $display("Counts: %0d checked, %0d failed", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // Hang guard, well past the few hundred cycles the tests need
    initial begin
        #100000;
        failures++;
        final_report;
    end
    // Main sequence
    initial begin
        seed = 32'hd195;
        {mem_rd_to_y, op_req, op_new_octet, op_to_y, op_x_to_first, reg_load, imm_load, imm_to_first, reg_to_first,
            param_valid, res_valid, maint_store, maint_from_y, copy_wb, copy_wb_to_y, fill_req, pairs_ready, slow,
            op_octet_addr, maint_addr, res_octet_addr, op_elem, res_elem, param_idx, op_size, op_src, res_size,
            reg_data, imm_data, res_data} = '0;
        rst = 1'b1;
        repeat (12) @(negedge clk);
        rst = 1'b0;
        // Register operand and start address A from imm_data
        reg_data = {$random(seed), $random(seed)};
        base = 21'($random(seed));
        imm_data = {43'h0, base};
        {reg_load, imm_load, param_valid} = 3'h7;
        @(negedge clk);
        {reg_load, imm_load, param_valid} = 3'h0;
        while (!mem_req) @(negedge clk);
        `CHK("read address", base, mem_req_addr)
        `CHK("start A", base, vec_a_start)
        wait (mem_rd_valid);
        repeat (4) @(negedge clk);
        $display("Test start address done");
        // Fill the operand queue with the pipeline stalled
        op_new_octet = 1'b1;
        for (n = 0; n < 40 && !op_busy; n++) begin
            op_elem = 4'($random(seed));
            op_size = 2'(($random(seed) & 32'h7fff_ffff) % 3);
            op_req = 1'b1;
            exp_q.push_back(pick(u_mem.octet(base), op_elem, op_size));
            @(negedge clk);
            {op_req, op_new_octet} = 2'h0;
            @(negedge clk);
        end
        `CHK("busy when full", 1'b1, op_busy)
        // Drain with random stalls, oldest first
        for (n = 0; n < 400 && exp_q.size() > 0; n++) begin
            @(negedge clk);
            pairs_ready = 1'($random(seed));
            if (pairs_valid && pairs_ready) begin
                e64 = exp_q.pop_front();
                `CHK("second pair", e64, second_operand_pair)
                `CHK("first pair", reg_data, first_operand_pair)
            end
        end
        `CHK("left over", 32'h0, 32'(exp_q.size()))
        $display("Test operand queue done");
        // A result in a new octet pushes the old one out as a write
        slow = 1'b1;
        {res_valid, res_size, res_elem, res_octet_addr} = {1'b1, 2'h1, 4'h6, base + 21'h1};
        res_data = {$random(seed), 32'h0};
        @(negedge clk);
        res_octet_addr = base + 21'h2;
        @(negedge clk);
        res_valid = 1'b0;
        while (!(mem_req && mem_req_write)) @(negedge clk);
        `CHK("write address", base + 21'h1, mem_req_addr)
        `CHK("write word", res_data[63:32], mem_wr_data[159 -: 32])
        `CHK("write zone", 8'h10, mem_wr_zone)
        repeat (10) @(negedge clk);
        $display("Test result write done");
        // Start address B also goes to memory at once
        imm_data = {43'h0, ~base};
        {param_idx, param_valid} = 4'h3;
        @(negedge clk);
        param_valid = 1'b0;
        while (!mem_req) @(negedge clk);
        `CHK("start B read", ~base, mem_req_addr)
        `CHK("start B", ~base, vec_b_start)
        repeat (8) @(negedge clk);
        $display("Test start address B done");
        final_report;
    end
endmodule

// ==== tb/mbop_mem_model.sv ====
// Private memory port model: acknowledges requests, returns octets
module mbop_mem_model (
    input  wire logic         clk,
    input  wire logic         slow,
    input  wire logic         mem_req,
    input  wire logic         mem_req_write,
    input  wire logic [20:0]  mem_req_addr,
    output logic              mem_req_ready,
    output logic              mem_rd_valid,
    output logic [255:0]      mem_rd_data
);
    timeunit 1ns;
    timeprecision 1ns;
    // Octet contents follow the address, so the bench can predict them
    function automatic logic [255:0] octet(input logic [20:0] a);
        for (int i = 0; i < 8; i++)
            octet[255 - 32 * i -: 32] = {a[7:0] + 8'(i), 8'h00, 8'(i) * 8'h93, a[15:8]};
    endfunction
    // One request at a time; slow mode inserts wait states
    initial begin
        mem_req_ready = 1'b0;
        mem_rd_valid  = 1'b0;
        mem_rd_data   = 256'h0;
        forever begin
            @(negedge clk);
            if (mem_req) begin
                repeat (slow ? 5 : 0) @(negedge clk);
                mem_rd_data   = octet(mem_req_addr);
                mem_req_ready = 1'b1;
                @(negedge clk);
                mem_req_ready = 1'b0;
                mem_rd_valid  = !mem_req_write;
                @(negedge clk);
                mem_rd_valid  = 1'b0;
                // Lines no longer hold the octet once the pulse ends
                mem_rd_data   = ~mem_rd_data;
            end
        end
    end
endmodule

// ==== verilog/mbop_buffer_unit.sv ====
`include "mbop_cfg.svh"
module mbop_buffer_unit
    import mbop_pkg::*;
#(
    parameter int words = `MBOP_WORDS
) (
    input  wire logic                           clk,
    input  wire logic                           rst,
    // Private memory controller port
    input  wire logic                           mem_rd_valid,
    input  wire logic [`MBOP_OCTET_BITS-1:0]    mem_rd_data,
    input  wire logic                           mem_rd_to_y,
    output logic                                mem_req,
    output logic                                mem_req_write,
    output logic [`MBOP_ADDR_BITS-1:0]          mem_req_addr,
    output logic [`MBOP_OCTET_BITS-1:0]         mem_wr_data,
    output logic [`MBOP_WORDS-1:0]              mem_wr_zone,
    input  wire logic                           mem_req_ready,
    // Operand requests from the instruction unit
    input  wire logic                           op_req,
    input  wire logic                           op_new_octet,
    input  wire logic [`MBOP_ADDR_BITS-1:0]     op_octet_addr,
    input  wire logic [`MBOP_ELEM_BITS-1:0]     op_elem,
    input  wire logic                           op_to_y,
    input  wire logic [1:0]                     op_size,
    input  wire logic [1:0]                     op_src,
    input  wire logic                           op_x_to_first,
    output logic                                op_busy,
    // Operand latches
    input  wire logic                           reg_load,
    input  wire logic [`MBOP_SEL_BITS-1:0]      reg_data,
    input  wire logic                           imm_load,
    input  wire logic [`MBOP_SEL_BITS-1:0]      imm_data,
    input  wire logic                           imm_to_first,
    input  wire logic                           reg_to_first,
    // Vector parameters, one word at a time
    input  wire logic                           param_valid,
    input  wire logic [`MBOP_PARAM_IDX_W-1:0]   param_idx,
    output logic [`MBOP_ADDR_BITS-1:0]          vec_a_start,
    output logic [`MBOP_ADDR_BITS-1:0]          vec_b_start,
    output logic [`MBOP_ADDR_BITS-1:0]          vec_c_start,
    // Results from the arithmetic pipeline
    input  wire logic                           res_valid,
    input  wire logic [`MBOP_ADDR_BITS-1:0]     res_octet_addr,
    input  wire logic [`MBOP_ELEM_BITS-1:0]     res_elem,
    input  wire logic [1:0]                     res_size,
    input  wire logic [`MBOP_SEL_BITS-1:0]      res_data,
    output logic                                res_stall,
    // Maintenance and write-buffer copy controls
    input  wire logic                           maint_store,
    input  wire logic                           maint_from_y,
    input  wire logic [`MBOP_ADDR_BITS-1:0]     maint_addr,
    input  wire logic                           copy_wb,
    input  wire logic                           copy_wb_to_y,
    input  wire logic                           fill_req,
    // Operand pairs to the pipeline
    output logic [`MBOP_SEL_BITS-1:0]           first_operand_pair,
    output logic [`MBOP_SEL_BITS-1:0]           second_operand_pair,
    output logic                                pairs_valid,
    input  wire logic                           pairs_ready
);
    localparam int wb = `MBOP_WORD_BITS;
    localparam int ob = `MBOP_OCTET_BITS;
    // Capture stage and buffer levels
    logic [ob-1:0] sync_capture_stage;          // Captured memory octet
    logic          cap_valid;                   // Capture holds an octet
    logic          cap_to_y;                    // Capture destination
    logic [ob-1:0] first_secondary_buffer;      // X second level
    logic [ob-1:0] second_secondary_buffer;     // Y second level
    logic [ob-1:0] first_tertiary_buffer;       // X working octet
    logic [ob-1:0] second_tertiary_buffer;      // Y working octet
    logic          xs_full;                     // X second level occupied
    logic          ys_full;                     // Y second level occupied
    // Write side
    logic [ob-1:0] wbuf;                        // Result write buffer
    logic [ob-1:0] write_staging_buffer;        // Octet bound for memory
    logic [`MBOP_ADDR_BITS-1:0] wbuf_addr;      // Octet held in write buffer
    logic [`MBOP_ADDR_BITS-1:0] stage_addr;     // Octet held in staging
    logic [15:0]   wbuf_mod;                    // Half-word modified bits
    logic [15:0]   stage_mod;                   // Half-word modified bits
    logic          wbuf_used;                   // Write buffer has data
    logic          stage_busy;                  // Staging write pending
    logic          fill_wait;                   // Waiting for fill octet
    // Latches
    logic [`MBOP_SEL_BITS-1:0] reg_latch;       // Register operand latch
    logic [`MBOP_SEL_BITS-1:0] literal_input_latch; // Immediate latch
    // Pending request port arbitration
    logic          start_pend;                  // Starting address to issue
    logic [`MBOP_ADDR_BITS-1:0] start_addr;     // Address to issue
    // Functions
    function automatic logic [`MBOP_SEL_BITS-1:0] sel_elem(
        input logic [ob-1:0] oct, input logic [3:0] e, input logic [1:0] sz);
        logic [wb-1:0] w;
        logic [15:0]   h;
        w = oct[ob-1-wb*e[3:1] -: wb];
        h = e[0] ? w[15:0] : w[31:16];
        // Halves sign extended to singles, singles in the upper word
        if (sz == mbop_size_half) sel_elem = {{16{h[15]}}, h, 32'h0000_0000};
        else if (sz == mbop_size_single) sel_elem = {w, 32'h0000_0000};
        else sel_elem = oct[ob-1-64*e[3:2] -: 64];
    endfunction
    function automatic logic [15:0] mod_mask(input logic [3:0] e, input logic [1:0] sz);
        if (sz == mbop_size_half) mod_mask = 16'h8000 >> e;
        else if (sz == mbop_size_single) mod_mask = 16'hc000 >> {e[3:1], 1'b0};
        else mod_mask = 16'hf000 >> {e[3:2], 2'b00};
    endfunction
    // Element selection from each working buffer
    wire [ob-1:0] x_oct = (op_new_octet && !op_to_y) ? first_secondary_buffer : first_tertiary_buffer;
    wire [ob-1:0] y_oct = (op_new_octet && op_to_y) ? second_secondary_buffer : second_tertiary_buffer;
    wire [`MBOP_SEL_BITS-1:0] x_sel = sel_elem(x_oct, op_elem, op_size);
    wire [`MBOP_SEL_BITS-1:0] y_sel = sel_elem(y_oct, op_elem, op_size);
    // Aligned result and its modify mask
    wire [15:0]    res_mask = mod_mask(res_elem, res_size);
    wire [ob-1:0]  res_spread = {8{res_size == mbop_size_half ? {2{res_data[47:32]}} : res_data[63:32]}};
    wire [ob-1:0]  res_wide = (res_size == mbop_size_double) ? {4{res_data}} : res_spread;
    wire [ob-1:0]  bit_mask;
    genvar g;
    for (g = 0; g < 16; g++) begin : g_mask
        assign bit_mask[ob-1-16*g -: 16] = {16{res_mask[15-g]}};
    end
    wire new_octet = res_valid && wbuf_used && (res_octet_addr != wbuf_addr);
    wire move_stall = new_octet && stage_busy;
    wire res_take = res_valid && !move_stall;
    // Half words need fill when a single has only one half written
    wire [7:0] part_def;
    for (g = 0; g < 8; g++) begin : g_part
        assign part_def[g] = stage_mod[2*g] ^ stage_mod[2*g+1];
    end
    wire need_fill = (part_def != 8'h00);
    wire stage_done = stage_busy && !fill_wait && mem_req && mem_req_write && mem_req_ready;
    // FIFO carrying selected operand pairs to the pipeline
    mbop_stream_if #(.width(2*`MBOP_SEL_BITS)) pair_in ();
    mbop_stream_if #(.width(2*`MBOP_SEL_BITS)) pair_out ();
    mbop_fifo #(.width(2*`MBOP_SEL_BITS), .depth(`MBOP_FIFO_DEPTH)) u_fifo (
        .clk   (clk),
        .rst   (rst),
        .fill  (pair_in),
        .drain (pair_out)
    );
    // Operand routing: x may reach either pair, y only the second
    wire [`MBOP_SEL_BITS-1:0] mem_operand = (op_src == mbop_src_sel_y) ? y_sel :
                                            (op_src == mbop_src_imm) ? literal_input_latch : x_sel;
    wire [`MBOP_SEL_BITS-1:0] next_first = (op_src == mbop_src_sel_x && op_x_to_first) ? x_sel :
                                           imm_to_first ? literal_input_latch :
                                           reg_latch;
    wire [`MBOP_SEL_BITS-1:0] next_second = (op_src == mbop_src_reg || reg_to_first == 1'b0 && op_src == mbop_src_reg)
                                            ? reg_latch : mem_operand;
    // A request waits while its octet is still being fetched
    wire op_wait = op_new_octet && ((op_to_y ? ys_full : xs_full) == 1'b0);
    assign pair_in.valid = op_req && !op_wait;
    assign pair_in.data  = {next_first, next_second};
    assign pair_out.ready = pairs_ready && pairs_valid || !pairs_valid;
    // Second level moves forward only when its request enters the FIFO
    wire x_move = pair_in.valid && pair_in.ready && op_new_octet && !op_to_y;
    wire y_move = pair_in.valid && pair_in.ready && op_new_octet && op_to_y;
    wire x_cap  = cap_valid && !fill_wait && !cap_to_y;
    wire y_cap  = cap_valid && !fill_wait && cap_to_y;
    // Pair outputs from registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            first_operand_pair  <= '0;
            second_operand_pair <= '0;
            pairs_valid         <= 1'b0;
            op_busy             <= 1'b0;
        end else begin
            if (pair_out.ready) begin
                pairs_valid <= pair_out.valid;
                if (pair_out.valid) {first_operand_pair, second_operand_pair} <= pair_out.data;
            end
            // Back-pressure from the FIFO reaches the instruction unit
            op_busy <= !pair_in.ready || op_wait;
        end
    end
    // Latches for register and literal words
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            reg_latch           <= '0;
            literal_input_latch <= '0;
        end else begin
            if (reg_load) reg_latch <= reg_data;
            if (imm_load || param_valid) literal_input_latch <= imm_data;
        end
    end
    // Vector parameters taken straight from imm_data
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            vec_a_start <= '0;
            vec_b_start <= '0;
            vec_c_start <= '0;
            start_pend  <= 1'b0;
            start_addr  <= '0;
        end else begin
            if (param_valid) begin
                // Starting addresses A and B go straight to memory
                case (param_idx)
                    `MBOP_PARAM_A_ADDR: vec_a_start <= imm_data[`MBOP_ADDR_BITS-1:0];
                    `MBOP_PARAM_B_ADDR: vec_b_start <= imm_data[`MBOP_ADDR_BITS-1:0];
                    `MBOP_PARAM_C_ADDR: vec_c_start <= imm_data[`MBOP_ADDR_BITS-1:0];
                    default: ;
                endcase
                if (param_idx == `MBOP_PARAM_A_ADDR || param_idx == `MBOP_PARAM_B_ADDR) begin
                    start_pend <= 1'b1;
                    start_addr <= imm_data[`MBOP_ADDR_BITS-1:0];
                end
            end else if (start_pend && mem_req && !mem_req_write && mem_req_ready) begin
                start_pend <= 1'b0;
            end
        end
    end
    // Capture stage; forwarded on the next clock unless a fill is waiting
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync_capture_stage      <= '0;
            cap_valid               <= 1'b0;
            cap_to_y                <= 1'b0;
            first_secondary_buffer  <= '0;
            second_secondary_buffer <= '0;
            first_tertiary_buffer   <= '0;
            second_tertiary_buffer  <= '0;
            xs_full                 <= 1'b0;
            ys_full                 <= 1'b0;
        end else begin
            cap_valid <= mem_rd_valid;
            if (mem_rd_valid) begin
                sync_capture_stage <= mem_rd_data;
                cap_to_y           <= mem_rd_to_y;
            end
            if (x_move) first_tertiary_buffer <= first_secondary_buffer;
            if (x_cap) first_secondary_buffer <= sync_capture_stage;
            xs_full <= x_cap || xs_full && !x_move;
            if (y_move) second_tertiary_buffer <= second_secondary_buffer;
            if (y_cap) second_secondary_buffer <= sync_capture_stage;
            ys_full <= y_cap || ys_full && !y_move;
            if (copy_wb && !copy_wb_to_y) first_tertiary_buffer <= wbuf;
            if (copy_wb && copy_wb_to_y) second_tertiary_buffer <= wbuf;
        end
    end
    // Write buffer, staging and half-word fill
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wbuf                 <= '0;
            wbuf_addr            <= '0;
            wbuf_mod             <= `MBOP_MOD_RESET;
            wbuf_used            <= 1'b0;
            write_staging_buffer <= '0;
            stage_addr           <= '0;
            stage_mod            <= `MBOP_MOD_RESET;
            stage_busy           <= 1'b0;
            fill_wait            <= 1'b0;
            res_stall            <= 1'b0;
        end else begin
            res_stall <= move_stall;
            if (stage_done) stage_busy <= 1'b0;
            if (res_take) begin
                if (new_octet) begin
                    write_staging_buffer <= wbuf;
                    stage_addr <= wbuf_addr;
                    stage_mod  <= wbuf_mod;
                    stage_busy <= 1'b1;
                    wbuf      <= res_wide & bit_mask;
                    wbuf_mod  <= res_mask;
                end else begin
                    wbuf     <= (wbuf & ~bit_mask) | (res_wide & bit_mask);
                    wbuf_mod <= wbuf_mod | res_mask;
                end
                wbuf_addr <= res_octet_addr;
                wbuf_used <= 1'b1;
            end
            // Fill request once staged; capture merges unwritten halves
            if (stage_busy && need_fill && fill_req) fill_wait <= 1'b1;
            if (fill_wait && cap_valid) begin
                for (int i = 0; i < 16; i++) begin
                    if (!stage_mod[15-i]) write_staging_buffer[ob-1-16*i -: 16] <= sync_capture_stage[ob-1-16*i -: 16];
                end
                stage_mod <= 16'hffff;
                fill_wait <= 1'b0;
            end
        end
    end
    // Zone bits: half-word modify bits combined in pairs
    wire [7:0] zone;
    for (g = 0; g < 8; g++) begin : g_zone
        assign zone[7-g] = stage_mod[15-2*g] | stage_mod[14-2*g];
    end
    wire maint_go = maint_store && !start_pend && !stage_busy;
    // Requests on the private port: starts first, then writes
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mem_req       <= 1'b0;
            mem_req_write <= 1'b0;
            mem_req_addr  <= '0;
            mem_wr_data   <= '0;
            mem_wr_zone   <= '0;
        end else if (!mem_req || mem_req_ready) begin
            mem_req       <= 1'b0;
            mem_req_write <= 1'b0;
            if (start_pend && !(mem_req && !mem_req_write && mem_req_addr == start_addr)) begin
                mem_req      <= 1'b1;
                mem_req_addr <= start_addr;
            end else if (stage_busy && !fill_wait && !(mem_req && mem_req_write)) begin
                mem_req       <= 1'b1;
                mem_req_write <= 1'b1;
                mem_req_addr  <= stage_addr;
                mem_wr_data   <= write_staging_buffer;
                mem_wr_zone   <= zone;
            end else if (maint_go) begin
                mem_req       <= 1'b1;
                mem_req_write <= 1'b1;
                mem_req_addr  <= maint_addr;
                mem_wr_data   <= maint_from_y ? second_tertiary_buffer : first_tertiary_buffer;
                mem_wr_zone   <= 8'hff;
            end
        end
    end
endmodule

// ==== verilog/mbop_cfg.svh ====
// Constants for the memory buffer operand path
`ifndef MBOP_CFG_SVH
`define MBOP_CFG_SVH
`define MBOP_WORDS        8
`define MBOP_WORD_BITS    32
`define MBOP_OCTET_BITS   256
`define MBOP_ADDR_BITS    21
`define MBOP_ELEM_BITS    4
`define MBOP_SEL_BITS     64
`define MBOP_FIFO_DEPTH   16
`define MBOP_PARAM_IDX_W  3
`define MBOP_PARAM_A_ADDR 3'h0
`define MBOP_PARAM_B_ADDR 3'h1
`define MBOP_PARAM_C_ADDR 3'h2
`define MBOP_MOD_RESET    16'h0000
`endif

// ==== verilog/mbop_fifo.sv ====
// Small FIFO memory with registered read data
module mbop_fifo #(
    parameter int width = 32,
    parameter int depth = 16
) (
    input  wire logic   clk,
    input  wire logic   rst,
    mbop_stream_if.sink fill,
    mbop_stream_if.source drain
);
    localparam int aw = $clog2(depth);
    logic [width-1:0] mem [depth];   // Storage
    logic [aw-1:0]    wr_ptr;        // Write pointer
    logic [aw-1:0]    rd_ptr;        // Read pointer
    logic [aw:0]      count;         // Words held in memory
    logic             out_valid;     // Output register full
    logic [width-1:0] out_data;      // Registered read data
    wire              do_push = fill.valid && fill.ready;
    wire              out_free = !out_valid || drain.ready;
    wire              do_pop = (count != '0) && out_free;
    assign fill.ready  = (count != (aw+1)'(depth));
    assign drain.valid = out_valid;
    assign drain.data  = out_data;
    // Memory write
    always_ff @(posedge clk) begin
        if (do_push) begin
            mem[wr_ptr] <= fill.data;
        end
    end
    // Pointers and count; read data leaves through a register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_ptr    <= '0;
            rd_ptr    <= '0;
            count     <= '0;
            out_valid <= 1'b0;
            out_data  <= '0;
        end else begin
            if (do_push) wr_ptr <= aw'(wr_ptr + 1'b1);
            if (do_pop) begin
                rd_ptr   <= aw'(rd_ptr + 1'b1);
                out_data <= mem[rd_ptr];
            end
            count <= (aw+1)'(count + do_push - do_pop);
            if (do_pop) out_valid <= 1'b1;
            else if (drain.ready) out_valid <= 1'b0;
        end
    end
endmodule

// ==== verilog/mbop_pkg.sv ====
// Types shared by the memory buffer operand path
package mbop_pkg;
    typedef enum logic [1:0] {
        mbop_size_half,
        mbop_size_single,
        mbop_size_double
    } mbop_size_type;
    typedef enum logic [1:0] {
        mbop_src_sel_x,
        mbop_src_sel_y,
        mbop_src_reg,
        mbop_src_imm
    } mbop_src_type;
endpackage

// ==== verilog/mbop_stream_if.sv ====
// Valid/ready word stream between the top and its FIFO
interface mbop_stream_if #(parameter int width = 32) ();
    logic             valid;   // Word offered
    logic             ready;   // Word accepted
    logic [width-1:0] data;    // Payload
    modport source (output valid, output data, input ready);
    modport sink   (input valid, input data, output ready);
endinterface
